// *** psd_pkg.sv ***
// package for the paged register-space address decoder
package psd_pkg;

    localparam logic [7:0] PSD_SPACE_LO     = 8'h80;
    localparam logic [7:0] PSD_SPACE_HI     = 8'hFF;
    localparam logic [7:0] PSD_PAGE_SEL_ADR = 8'hA7;
    localparam logic [7:0] PSD_PAGE_SEL_RST = 8'h00;
    localparam logic [7:0] PSD_PAGE_DEFAULT = 8'h00;
    localparam logic [7:0] PSD_PAGE_SECOND  = 8'h0F;
    localparam logic [3:0] PSD_BIT_NIB_A    = 4'h0;
    localparam logic [3:0] PSD_BIT_NIB_B    = 4'h8;
    localparam int         PSD_NUM_SLOTS    = 128;

    // where an address lands after decoding
    typedef enum logic [1:0] {
        PSD_TGT_NONE,
        PSD_TGT_SELF,
        PSD_TGT_DEFAULT,
        PSD_TGT_SECOND
    } psd_tgt_t;

    // one access from the core
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       bit_mode;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psd_req_t;

    // one routed access toward the peripherals
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] slot;
        logic [7:0] wdata;
    } psd_route_t;

endpackage

// *** psd_decoder.sv ***
// paged register-space address decoder with page-select register
// How it works
// R1: direct addresses 0x80..0xFF go to the register space, not data memory
// R2: only addresses ending 0x0 or 0x8 take bit accesses; others byte only
// R3: software must not touch unoccupied locations; their effect is undefined
// R4: after reset all accesses target the default page 0x0
// R5: 8-bit read/write page-select register, reset zero, steers every access except to itself and shared registers
// R6: page-select sits at 0xA7 on every page, like other shared registers
// R7: page-select value 0x0F exposes the secondary page register set
// R8: secondary-only registers answer only on page 0xF, default-only ones only on page 0x0
// R9: software saves and clears interrupt enable around secondary page work
// R10: bit access hits byte at address with low three bits cleared
// R11: empty or undefined-page locations read zero and ignore writes
module psd_decoder
    import psd_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    input  wire psd_req_t                 req,
    input  wire logic [PSD_NUM_SLOTS-1:0] dflt_present,
    input  wire logic [PSD_NUM_SLOTS-1:0] second_present,
    input  wire logic [PSD_NUM_SLOTS-1:0] shared_present,
    input  wire logic [7:0]               dflt_rdata,
    input  wire logic [7:0]               second_rdata,
    output psd_route_t                    dflt_route,
    output psd_route_t                    second_route,
    output logic                          space_hit,
    output logic                          bit_refused,
    output logic [7:0]                    rdata,
    output logic [7:0]                    register_page_select
);

    // page register
    logic [7:0] page_ff;
    logic [7:0] nxt_page;
    logic       page_wr;

    // decoded address
    logic [7:0] byte_addr;
    logic [6:0] slot;
    logic [2:0] bit_pos;
    logic       in_space;
    logic       bit_ok;
    logic       access_ok;
    logic       self_hit;

    // page and target
    logic       page_is_dflt;
    logic       page_is_second;
    logic       dflt_here;
    logic       second_here;
    logic       shared_here;
    logic       on_dflt;
    logic       on_second;
    psd_tgt_t   tgt;
    logic       sel_self;
    logic       sel_dflt;
    logic       sel_second;
    logic [7:0] byte_rd;
    logic [7:0] byte_wr;
    logic [7:0] bit_rd;

    // address lies in the register space rather than data memory
    function automatic logic in_reg_space(input logic [7:0] a);
        return (a >= PSD_SPACE_LO) && (a <= PSD_SPACE_HI);
    endfunction

    // true when an address may be reached with a single-bit access
    function automatic logic bit_addressable(input logic [7:0] a);
        return (a[3:0] == PSD_BIT_NIB_A) || (a[3:0] == PSD_BIT_NIB_B);
    endfunction

    // byte register that holds a bit address
    function automatic logic [7:0] bit_home(input logic [7:0] a);
        return {a[7:3], 3'h0};
    endfunction

    // byte with one bit replaced
    function automatic logic [7:0] merge_bit(
        input logic [7:0] b,
        input logic [2:0] pos,
        input logic       val
    );
        logic [7:0] m;
        m      = b;
        m[pos] = val;
        return m;
    endfunction

    // one selected bit, presented in bit 0
    function automatic logic [7:0] pick_bit(
        input logic [7:0] b,
        input logic [2:0] pos
    );
        return {7'h00, b[pos]};
    endfunction

    // strobes toward one page, quiet unless that page was chosen
    function automatic psd_route_t make_route(
        input logic       sel,
        input psd_req_t   r,
        input logic [6:0] s,
        input logic [7:0] d
    );
        psd_route_t o;
        o.rd    = r.rd && sel;
        o.wr    = r.wr && sel;
        o.slot  = s;
        o.wdata = d;
        return o;
    endfunction

    // address decode
    assign byte_addr = req.bit_mode ? bit_home(req.addr) : req.addr; // R10
    assign bit_pos   = req.addr[2:0]; // R10
    assign in_space  = in_reg_space(byte_addr); // R1
    assign slot      = byte_addr[6:0];
    assign bit_ok    = !req.bit_mode || bit_addressable(byte_addr); // R2
    assign access_ok = in_space && bit_ok;
    assign self_hit  = (byte_addr == PSD_PAGE_SEL_ADR); // R6

    // page decode
    assign page_is_dflt   = (page_ff == PSD_PAGE_DEFAULT); // R4
    assign page_is_second = (page_ff == PSD_PAGE_SECOND); // R7
    assign dflt_here      = dflt_present[slot];
    assign second_here    = second_present[slot];
    assign shared_here    = shared_present[slot];
    assign on_dflt        = dflt_here && (page_is_dflt || shared_here); // R8
    assign on_second      = second_here && page_is_second; // R8

    // page select first, then secondary on page 0xF, then shared on any page and default on page 0x0 only
    always_comb
    begin
        tgt = PSD_TGT_NONE; // R11
        if (!access_ok)
        begin
            tgt = PSD_TGT_NONE; // R1
        end
        else if (self_hit)
        begin
            tgt = PSD_TGT_SELF; // R6
        end
        else if (on_second)
        begin
            tgt = PSD_TGT_SECOND; // R8
        end
        else if (on_dflt)
        begin
            tgt = PSD_TGT_DEFAULT; // R4
        end
        else
        begin
            tgt = PSD_TGT_NONE; // R11
        end
    end

    // one-hot selects of the chosen target
    assign sel_self   = (tgt == PSD_TGT_SELF); // R6
    assign sel_dflt   = (tgt == PSD_TGT_DEFAULT); // R4
    assign sel_second = (tgt == PSD_TGT_SECOND); // R8

    // space and bit status toward the core
    assign space_hit   = in_space; // R1
    assign bit_refused = in_space && !bit_ok; // R2

    // read data of the chosen target, zero where nothing answers
    always_comb
    begin
        unique case (tgt)
            PSD_TGT_SELF:
            begin
                byte_rd = page_ff; // R6
            end
            PSD_TGT_DEFAULT:
            begin
                byte_rd = dflt_rdata; // R4
            end
            PSD_TGT_SECOND:
            begin
                byte_rd = second_rdata; // R7
            end
            PSD_TGT_NONE:
            begin
                byte_rd = 8'h00; // R11
            end
        endcase
    end

    // bit writes are read-modify-write of the addressed byte
    always_comb
    begin
        if (req.bit_mode)
        begin
            byte_wr = merge_bit(byte_rd, bit_pos, req.wdata[0]); // R10
        end
        else
        begin
            byte_wr = req.wdata;
        end
    end

    // bit reads present the selected bit alone
    assign bit_rd = pick_bit(byte_rd, bit_pos); // R10
    assign rdata  = req.bit_mode ? bit_rd : byte_rd; // R10

    // routes toward the two peripheral pages
    assign dflt_route   = make_route(sel_dflt, req, slot, byte_wr); // R11
    assign second_route = make_route(sel_second, req, slot, byte_wr); // R8

    // page register, written through its own address on every page
    assign page_wr  = req.wr && sel_self; // R6
    assign nxt_page = page_wr ? byte_wr : page_ff; // R5

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            page_ff <= PSD_PAGE_SEL_RST; // R4
        end
        else
        begin
            page_ff <= nxt_page; // R5
        end
    end

    assign register_page_select = page_ff; // R5

endmodule

// *** psd_props.sv ***
// port assertions for the paged register decoder
module psd_chk
    import psd_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       space_hit,
    input wire logic       bit_refused,
    input wire psd_req_t   req,
    input wire psd_route_t dflt_route,
    input wire psd_route_t second_route,
    input wire logic [7:0] register_page_select
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    wire       b  = req.bit_mode;
    wire       pw = req.wr && !b && (req.addr == PSD_PAGE_SEL_ADR);
    wire [7:0] pg = register_page_select;

    property p_lo;
        !req.addr[7] && !b |-> !dflt_route.rd && !dflt_route.wr;
    endproperty
    a_lo: assert property (p_lo) else $error("low address routed");
    property p_out;
        !space_hit |-> !second_route.rd && !second_route.wr;
    endproperty
    a_out: assert property (p_out) else $error("outside access routed");
    property p_hi;
        req.addr[7] && !b |-> space_hit;
    endproperty
    a_hi: assert property (p_hi) else $error("high address missed");
    property p_bit;
        b |-> !bit_refused;
    endproperty
    a_bit: assert property (p_bit) else $error("bit access refused");
    property p_rst;
        $rose(nrst) |-> pg == PSD_PAGE_SEL_RST;
    endproperty
    a_rst: assert property (p_rst) else $error("page not reset");
    property p_wr;
        pw |=> pg == $past(req.wdata);
    endproperty
    a_wr: assert property (p_wr) else $error("page write lost");
    property p_hold;
        !pw |=> $stable(pg);
    endproperty
    a_hold: assert property (p_hold) else $error("page changed");
    property p_sec;
        pg != PSD_PAGE_SECOND |-> !second_route.rd && !second_route.wr;
    endproperty
    a_sec: assert property (p_sec) else $error("second page leak");
    property p_bm;
        b && dflt_route.rd |-> dflt_route.slot[2:0] == 3'h0;
    endproperty
    a_bm: assert property (p_bm) else $error("bit byte wrong");

    c_sec: cover property (second_route.rd);
    c_bit: cover property (b && dflt_route.wr);
    c_pw: cover property (pw);
    c_rst: cover property ($rose(nrst));
endmodule

bind psd_decoder psd_chk psd_chk_i (
    .core_clk             (core_clk),
    .nrst                 (nrst),
    .space_hit            (space_hit),
    .bit_refused          (bit_refused),
    .req                  (req),
    .dflt_route           (dflt_route),
    .second_route         (second_route),
    .register_page_select (register_page_select)
);

// *** psd_periph.sv ***
// peripheral registers of both pages, the far side of the decoder
module psd_periph
    import psd_pkg::*;
(
    input  wire logic       core_clk,
    input  wire psd_route_t dflt_route,
    input  wire psd_route_t second_route,
    output logic [7:0]      dflt_rdata,
    output logic [7:0]      second_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] dflt_mem   [PSD_NUM_SLOTS];
    logic [7:0] second_mem [PSD_NUM_SLOTS];

    assign dflt_rdata   = dflt_mem[dflt_route.slot];
    assign second_rdata = second_mem[second_route.slot];

    always_ff @(posedge core_clk)
    begin
        if (dflt_route.wr)
        begin
            dflt_mem[dflt_route.slot] <= dflt_route.wdata;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (second_route.wr)
        begin
            second_mem[second_route.slot] <= second_route.wdata;
        end
    end
endmodule

// *** psd_decoder_tb_top.sv ***
// bench for the paged register decoder
module psd_decoder_tb_top import psd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    // access kinds as {rd, wr, bit_mode}
    localparam logic [2:0] RD_BYTE = 3'h4;
    localparam logic [2:0] WR_BYTE = 3'h2;
    localparam logic [2:0] WR_BIT  = 3'h3;
    localparam logic [2:0] RD_BIT  = 3'h5;

    logic                     core_clk  = 1'b0;
    logic                     nrst      = 1'b0;
    psd_req_t                 req       = '0;
    logic                     space_hit;
    logic                     bit_refused;
    psd_route_t               dflt_route;
    psd_route_t               second_route;
    logic [7:0]               rdata;
    logic [7:0]               register_page_select;
    logic [7:0]               dflt_rdata;
    logic [7:0]               second_rdata;
    logic [PSD_NUM_SLOTS-1:0] dflt_present;
    logic [PSD_NUM_SLOTS-1:0] second_present;
    logic [PSD_NUM_SLOTS-1:0] shared_present;
    int                       error_cnt = 0;
    int                       n_tests   = 0;

    assign dflt_present   = ~(128'h1 << 8'h34);
    assign second_present = 128'h1 << 8'h3A;
    assign shared_present = 128'h1 << 8'h60;

    psd_decoder psd_decoder_i (
        .core_clk             (core_clk),
        .nrst                 (nrst),
        .req                  (req),
        .dflt_present         (dflt_present),
        .second_present       (second_present),
        .shared_present       (shared_present),
        .dflt_rdata           (dflt_rdata),
        .second_rdata         (second_rdata),
        .dflt_route           (dflt_route),
        .second_route         (second_route),
        .space_hit            (space_hit),
        .bit_refused          (bit_refused),
        .rdata                (rdata),
        .register_page_select (register_page_select)
    );

    psd_periph psd_periph_i (
        .core_clk     (core_clk),
        .dflt_route   (dflt_route),
        .second_route (second_route),
        .dflt_rdata   (dflt_rdata),
        .second_rdata (second_rdata)
    );

    initial forever #10 core_clk = ~core_clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] expd);
        n_tests++;
        if (seen !== expd)
        begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, expd);
        end
    endtask

    // one access held across one rising edge, then an idle cycle
    task automatic ac(input logic [2:0] m, input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk);
        req = {m, a, m[2] ? 8'h00 : v};
        #5;
        chk({7'h00, space_hit}, {7'h00, a[7]});
        chk({7'h00, bit_refused}, 8'h00);
        if (m[2])
        begin
            chk(rdata, v);
        end
        @(negedge core_clk);
        req = '0;
    endtask

    task automatic end_sim;
        if (error_cnt == 0 && n_tests > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog: the tests need well under 200 cycles
    initial
    begin
        #10us;
        error_cnt++;
        end_sim;
    end

    initial
    begin
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        chk(register_page_select, PSD_PAGE_SEL_RST);
        ac(RD_BYTE, 8'hA7, 8'h00);
        ac(WR_BYTE, 8'hBA, 8'h55);
        ac(RD_BYTE, 8'hB4, 8'h00);
        ac(WR_BYTE, 8'h3A, 8'h99);
        ac(RD_BYTE, 8'h3A, 8'h00);
        ac(RD_BYTE, 8'hBA, 8'h55);
        ac(WR_BYTE, 8'hE0, 8'h00);
        ac(WR_BIT, 8'hE3, 8'h01);
        ac(RD_BYTE, 8'hE0, 8'h08);
        ac(RD_BIT, 8'hE3, 8'h01);
        ac(RD_BIT, 8'hE4, 8'h00);
        ac(WR_BYTE, 8'hA7, 8'h0F);
        ac(RD_BYTE, 8'hA7, 8'h0F);
        ac(WR_BYTE, 8'hBA, 8'hAA);
        ac(RD_BYTE, 8'hBA, 8'hAA);
        ac(RD_BYTE, 8'hE0, 8'h08);
        ac(WR_BYTE, 8'hA7, 8'h3C);
        ac(WR_BYTE, 8'hBA, 8'h77);
        ac(RD_BYTE, 8'hBA, 8'h00);
        ac(WR_BYTE, 8'hA7, 8'h00);
        ac(RD_BYTE, 8'hBA, 8'h55);
        ac(WR_BYTE, 8'hA7, 8'h0F);
        ac(RD_BYTE, 8'hBA, 8'hAA);
        @(negedge core_clk);
        nrst = 1'b0;
        @(negedge core_clk);
        chk(register_page_select, PSD_PAGE_SEL_RST);
        @(negedge core_clk);
        nrst = 1'b1;
        ac(RD_BYTE, 8'hA7, 8'h00);
        ac(RD_BYTE, 8'hBA, 8'h55);
        end_sim;
    end
endmodule
